/* design/pmct_core_timing.v */
// Instruction length decode and clock-cycle sequencer of the pipelined core
// ****************************************
// Overview of operation
// ****************************************
`include "pmct_timing_regs.vh"
`default_nettype none

module pmct_core_timing (
    input wire clk_in,
    input wire resetn_in,
    input wire [7:0] code_byte_in,
    input wire code_valid_in,
    input wire branch_taken_in,
    output reg code_ready_out,
    output reg busy_out,
    output reg retire_out,
    output reg [7:0] ret_opcode_out,
    output reg [7:0] ret_operand1_out,
    output reg [7:0] ret_operand2_out,
    output reg [`PMCT_LEN_W-1:0] ret_length_out,
    output reg [`PMCT_CYC_W-1:0] ret_cycles_out,
    output reg ret_taken_out,
    output reg ret_undefined_out
);

    // ****************************************
    // States
    // ****************************************
    localparam [2:0] ST_OPC = 3'h1;
    localparam [2:0] ST_OPR = 3'h2;
    localparam [2:0] ST_EXE = 3'h4;

    // ****************************************
    // Opcode decode: length, base clocks, conditional flag
    // ****************************************
    function [`PMCT_ENT_W-1:0] pmct_decode;
        input [7:0] op;
        begin
            casez (op)
                // Column zero: no operation and bit branches
                8'h00: pmct_decode = `PMCT_T11;
                8'h10: pmct_decode = `PMCT_C33;
                8'h20: pmct_decode = `PMCT_C33;
                8'h30: pmct_decode = `PMCT_C33;
                // Relative branches on carry and accumulator
                8'h40: pmct_decode = `PMCT_C22;
                8'h50: pmct_decode = `PMCT_C22;
                8'h60: pmct_decode = `PMCT_C22;
                8'h70: pmct_decode = `PMCT_C22;
                8'h80: pmct_decode = `PMCT_T23;
                8'h90: pmct_decode = `PMCT_T33;
                8'ha0: pmct_decode = `PMCT_T22;
                8'hb0: pmct_decode = `PMCT_T22;
                8'hc0: pmct_decode = `PMCT_T22;
                8'hd0: pmct_decode = `PMCT_T22;
                8'he0: pmct_decode = `PMCT_T13;
                8'hf0: pmct_decode = `PMCT_T13;
                // Absolute jumps and calls
                8'b????0001: pmct_decode = `PMCT_T23;
                // Column two
                8'h02: pmct_decode = `PMCT_T34;
                8'h12: pmct_decode = `PMCT_T34;
                8'h22: pmct_decode = `PMCT_T15;
                8'h32: pmct_decode = `PMCT_T15;
                8'h42: pmct_decode = `PMCT_T22;
                8'h52: pmct_decode = `PMCT_T22;
                8'h62: pmct_decode = `PMCT_T22;
                8'h72: pmct_decode = `PMCT_T22;
                8'h82: pmct_decode = `PMCT_T22;
                8'h92: pmct_decode = `PMCT_T22;
                8'ha2: pmct_decode = `PMCT_T22;
                8'hb2: pmct_decode = `PMCT_T22;
                8'hc2: pmct_decode = `PMCT_T22;
                8'hd2: pmct_decode = `PMCT_T22;
                8'he2: pmct_decode = `PMCT_T13;
                8'hf2: pmct_decode = `PMCT_T13;
                // Column three
                8'h03: pmct_decode = `PMCT_T11;
                8'h13: pmct_decode = `PMCT_T11;
                8'h23: pmct_decode = `PMCT_T11;
                8'h33: pmct_decode = `PMCT_T11;
                8'h43: pmct_decode = `PMCT_T33;
                8'h53: pmct_decode = `PMCT_T33;
                8'h63: pmct_decode = `PMCT_T33;
                8'h73: pmct_decode = `PMCT_T13;
                8'h83: pmct_decode = `PMCT_T13;
                8'h93: pmct_decode = `PMCT_T13;
                8'ha3: pmct_decode = `PMCT_T11;
                8'hb3: pmct_decode = `PMCT_T11;
                8'hc3: pmct_decode = `PMCT_T11;
                8'hd3: pmct_decode = `PMCT_T11;
                8'he3: pmct_decode = `PMCT_T13;
                8'hf3: pmct_decode = `PMCT_T13;
                // Column four
                8'h04: pmct_decode = `PMCT_T11;
                8'h14: pmct_decode = `PMCT_T11;
                8'h24: pmct_decode = `PMCT_T22;
                8'h34: pmct_decode = `PMCT_T22;
                8'h44: pmct_decode = `PMCT_T22;
                8'h54: pmct_decode = `PMCT_T22;
                8'h64: pmct_decode = `PMCT_T22;
                8'h74: pmct_decode = `PMCT_T22;
                8'h94: pmct_decode = `PMCT_T22;
                8'h84: pmct_decode = `PMCT_T18;
                8'ha4: pmct_decode = `PMCT_T14;
                8'hb4: pmct_decode = `PMCT_C33;
                8'hc4: pmct_decode = `PMCT_T11;
                8'hd4: pmct_decode = `PMCT_T11;
                8'he4: pmct_decode = `PMCT_T11;
                8'hf4: pmct_decode = `PMCT_T11;
                // Column five
                8'ha5: pmct_decode = `PMCT_UNDEF;
                8'h75: pmct_decode = `PMCT_T33;
                8'h85: pmct_decode = `PMCT_T33;
                8'hb5: pmct_decode = `PMCT_C33;
                8'hd5: pmct_decode = `PMCT_C33;
                8'b????0101: pmct_decode = `PMCT_T22;
                // Columns six and seven
                8'b0111011?: pmct_decode = `PMCT_T22;
                8'b1000011?: pmct_decode = `PMCT_T22;
                8'b1010011?: pmct_decode = `PMCT_T22;
                8'b1011011?: pmct_decode = `PMCT_C34;
                8'b????011?: pmct_decode = `PMCT_T12;
                // Columns eight to fifteen
                8'b01111???: pmct_decode = `PMCT_T22;
                8'b10001???: pmct_decode = `PMCT_T22;
                8'b10101???: pmct_decode = `PMCT_T22;
                8'b10111???: pmct_decode = `PMCT_C33;
                8'b11011???: pmct_decode = `PMCT_C22;
                // Register forms and the rest
                default: pmct_decode = `PMCT_T11;
            endcase
        end
    endfunction

    // ****************************************
    // State and next-state
    // ****************************************
    reg [2:0] state_q, state_d;
    reg [7:0] op_q, op_d;
    reg [7:0] opr1_q, opr1_d;
    reg [7:0] opr2_q, opr2_d;
    reg [`PMCT_LEN_W-1:0] len_q, len_d;
    reg [`PMCT_LEN_W-1:0] nbyte_q, nbyte_d;
    reg [`PMCT_CYC_W-1:0] cyc_q, cyc_d;
    reg [`PMCT_CYC_W-1:0] cnt_q, cnt_d;
    reg cond_q, cond_d;
    reg undef_q, undef_d;
    reg ext_q, ext_d;
    reg fin_d;
    reg at_target;
    reg [`PMCT_ENT_W-1:0] ent;
    wire take_byte;

    assign take_byte = code_valid_in & code_ready_out;

    always @* begin
        state_d = state_q;
        op_d = op_q;
        opr1_d = opr1_q;
        opr2_d = opr2_q;
        len_d = len_q;
        nbyte_d = nbyte_q;
        cyc_d = cyc_q;
        cnt_d = cnt_q;
        cond_d = cond_q;
        undef_d = undef_q;
        ext_d = ext_q;
        fin_d = 1'b0;
        at_target = 1'b0;
        ent = pmct_decode(code_byte_in);
        case (state_q)
            ST_OPC: begin
                if (take_byte) begin
                    op_d = code_byte_in;
                    opr1_d = `PMCT_BYTE_ZERO;
                    opr2_d = `PMCT_BYTE_ZERO;
                    len_d = ent[`PMCT_F_LEN];
                    cyc_d = ent[`PMCT_F_CYC];
                    cond_d = ent[`PMCT_F_COND];
                    undef_d = ent[`PMCT_F_UNDEF];
                    ext_d = 1'b0;
                    nbyte_d = `PMCT_LEN_ONE;
                    cnt_d = `PMCT_CYC_ONE;
                    if (ent[`PMCT_F_LEN] != `PMCT_LEN_ONE) begin
                        state_d = ST_OPR;
                    end else if (ent[`PMCT_F_CYC] == `PMCT_CYC_ONE) begin
                        fin_d = 1'b1;
                    end else begin
                        state_d = ST_EXE;
                    end
                end
            end
            ST_OPR: begin
                if (take_byte) begin
                    nbyte_d = nbyte_q + `PMCT_LEN_ONE;
                    cnt_d = cnt_q + `PMCT_CYC_ONE;
                    if (nbyte_q == `PMCT_LEN_ONE) begin
                        opr1_d = code_byte_in;
                    end else begin
                        opr2_d = code_byte_in;
                    end
                    if (nbyte_d == len_q) begin
                        state_d = ST_EXE;
                        at_target = (cnt_d == cyc_q);
                    end
                end
            end
            ST_EXE: begin
                cnt_d = cnt_q + `PMCT_CYC_ONE;
                at_target = (cnt_d == cyc_q + {{(`PMCT_CYC_W-1){1'b0}}, ext_q});
            end
            default: begin
                state_d = ST_OPC;
            end
        endcase
        if (at_target) begin
            if (cond_q && !ext_q && branch_taken_in) begin
                ext_d = 1'b1;
                state_d = ST_EXE;
            end else begin
                fin_d = 1'b1;
            end
        end
        if (fin_d) begin
            state_d = ST_OPC;
        end
    end

    // ****************************************
    // Registers and retire outputs
    // ****************************************
    always @(posedge clk_in) begin
        if (!resetn_in) begin
            state_q <= ST_OPC;
            op_q <= `PMCT_BYTE_ZERO;
            opr1_q <= `PMCT_BYTE_ZERO;
            opr2_q <= `PMCT_BYTE_ZERO;
            len_q <= `PMCT_LEN_ONE;
            nbyte_q <= `PMCT_LEN_ONE;
            cyc_q <= `PMCT_CYC_ONE;
            cnt_q <= `PMCT_CYC_ZERO;
            cond_q <= 1'b0;
            undef_q <= 1'b0;
            ext_q <= 1'b0;
            code_ready_out <= 1'b0;
            busy_out <= 1'b0;
            retire_out <= 1'b0;
            ret_opcode_out <= `PMCT_BYTE_ZERO;
            ret_operand1_out <= `PMCT_BYTE_ZERO;
            ret_operand2_out <= `PMCT_BYTE_ZERO;
            ret_length_out <= `PMCT_LEN_ONE;
            ret_cycles_out <= `PMCT_CYC_ZERO;
            ret_taken_out <= 1'b0;
            ret_undefined_out <= 1'b0;
        end else begin
            state_q <= state_d;
            op_q <= op_d;
            opr1_q <= opr1_d;
            opr2_q <= opr2_d;
            len_q <= len_d;
            nbyte_q <= nbyte_d;
            cyc_q <= cyc_d;
            cnt_q <= cnt_d;
            cond_q <= cond_d;
            undef_q <= undef_d;
            ext_q <= ext_d;
            code_ready_out <= (state_d != ST_EXE);
            busy_out <= (state_d != ST_OPC);
            retire_out <= fin_d;
            if (fin_d) begin
                ret_opcode_out <= op_d;
                ret_operand1_out <= opr1_d;
                ret_operand2_out <= opr2_d;
                ret_length_out <= len_d;
                ret_cycles_out <= cnt_d;
                ret_taken_out <= ext_d;
                ret_undefined_out <= undef_d;
            end
        end
    end

endmodule

`default_nettype wire

/* common/pmct_timing_regs.vh */
// Decode table encodings and timing constants for the core timing sequencer
`ifndef PMCT_TIMING_REGS_VH
`define PMCT_TIMING_REGS_VH

// ****************************************
// Field layout of one decode entry {undef, cond, len, cycles}
// ****************************************
`define PMCT_ENT_W 8
`define PMCT_F_CYC 3:0
`define PMCT_F_LEN 5:4
`define PMCT_F_COND 6
`define PMCT_F_UNDEF 7

// ****************************************
// Widths and limits
// ****************************************
`define PMCT_CYC_W 4
`define PMCT_LEN_W 2
`define PMCT_MAX_CYC 4'h8
`define PMCT_FMAX_MHZ 25
`define PMCT_LEN_ONE 2'h1
`define PMCT_CYC_ONE 4'h1
`define PMCT_CYC_ZERO 4'h0
`define PMCT_BYTE_ZERO 8'h00

// ****************************************
// Decode entries: T<len><cycles>, C<len><base cycles> = conditional
// ****************************************
`define PMCT_T11 8'h11
`define PMCT_T12 8'h12
`define PMCT_T13 8'h13
`define PMCT_T14 8'h14
`define PMCT_T15 8'h15
`define PMCT_T18 8'h18
`define PMCT_T22 8'h22
`define PMCT_T23 8'h23
`define PMCT_T33 8'h33
`define PMCT_T34 8'h34
`define PMCT_C22 8'h62
`define PMCT_C33 8'h73
`define PMCT_C34 8'h74
`define PMCT_UNDEF 8'h91

`endif

/* tb/pmct_core_timing_props.sv */
// Timing checker for the core sequencer
`default_nettype none
module pmct_core_timing_chk (
    input wire logic clk_in,
    input wire logic resetn_in,
    input wire logic [7:0] code_byte_in,
    input wire logic code_valid_in,
    input wire logic code_ready_out,
    input wire logic busy_out,
    input wire logic retire_out,
    input wire logic [7:0] ret_opcode_out,
    input wire logic [1:0] ret_length_out,
    input wire logic [3:0] ret_cycles_out,
    input wire logic ret_taken_out
);
    timeunit 1ns;
    timeprecision 100ps;
    default clocking cb @(posedge clk_in); endclocking
    default disable iff (!resetn_in);
    wire [7:0] op = ret_opcode_out;
    wire [5:0] lc = {ret_length_out, ret_cycles_out};
    wire alu = retire_out && (op[7:4] inside {4'h2, 4'h3, 4'h4, 4'h5, 4'h6, 4'h9});
    // Opcode accepted while no instruction is in flight
    sequence start(b);
        code_ready_out && code_valid_in && !busy_out && code_byte_in == b;
    endsequence
    chk_reg_one: assert property (alu && op[3] |-> lc == 6'h11)
        else $error("register op timing");
    chk_ind_two: assert property (alu && op[3:1] == 3'h3 |-> lc == 6'h12)
        else $error("indirect op timing");
    chk_dir_imm: assert property (alu && op[3:1] == 3'h2 |-> lc == 6'h22)
        else $error("direct or immediate op timing");
    chk_imm_dir: assert property (retire_out && op inside {8'h43, 8'h53, 8'h63} |-> lc == 6'h33)
        else $error("immediate into direct timing");
    chk_acc_dir: assert property (retire_out && op inside {8'h42, 8'h52, 8'h62} |-> lc == 6'h22)
        else $error("acc into direct timing");
    chk_inc_dec: assert property (retire_out && op inside {8'h05, 8'h06, 8'h07, 8'h15, 8'h16, 8'h17}
        |-> lc == (op[1:0] == 2'h1 ? 6'h22 : 6'h12)) else $error("inc dec timing");
    chk_cycle_cap: assert property (retire_out |-> ret_cycles_out inside {[4'h1:4'h8]})
        else $error("cycle count out of range");
    chk_branch_save: assert property (retire_out && op == 8'h40
        |-> ret_cycles_out == 4'h2 + {3'h0, ret_taken_out}) else $error("branch timing");
    chk_bit_jump: assert property (retire_out && op == 8'h10
        |-> lc == 6'h33 + {5'h0, ret_taken_out}) else $error("bit jump timing");
    chk_div_steps: assert property (start(8'h84) |=> !code_ready_out [*7] ##1
        (retire_out && ret_cycles_out == 4'h8)) else $error("divide sequence");
    chk_one_clock: assert property (start(8'h28) |=> retire_out && code_ready_out)
        else $error("single clock throughput");
endmodule
bind pmct_core_timing pmct_core_timing_chk chk_u (.clk_in(clk_in), .resetn_in(resetn_in),
    .code_byte_in(code_byte_in), .code_valid_in(code_valid_in), .code_ready_out(code_ready_out),
    .busy_out(busy_out), .retire_out(retire_out), .ret_opcode_out(ret_opcode_out),
    .ret_length_out(ret_length_out), .ret_cycles_out(ret_cycles_out), .ret_taken_out(ret_taken_out));
`default_nettype wire

/* tb/pmct_code_mem.sv */
// Program memory model streaming code bytes to the core
`default_nettype none
module pmct_code_mem (
    input wire logic clk_in,
    input wire logic restart_in,
    input wire logic stall_in,
    input wire logic ready_in,
    output logic [7:0] byte_out,
    output logic valid_out
);
    timeunit 1ns;
    timeprecision 100ps;
    logic [7:0] mem_q [0:63];
    int fill = 0;
    int ptr_q = 0;
    logic gap_q = 1'b0;
    initial foreach (mem_q[i]) mem_q[i] = 8'h00;
    // Slow mode idles one cycle after each byte; an offered byte is held until taken
    assign valid_out = !restart_in && ptr_q < fill && !(stall_in && gap_q);
    // Idle bus shows inverted data so stale bytes never look valid
    assign byte_out = valid_out ? mem_q[ptr_q[5:0]] : ~mem_q[ptr_q[5:0]];
    always @(posedge clk_in) begin
        gap_q <= valid_out && ready_in;
        if (restart_in)
            ptr_q <= 0;
        else if (valid_out && ready_in)
            ptr_q <= ptr_q + 1;
    end
endmodule
`default_nettype wire

/* tb/pmct_core_timing_bench.sv */
// Self-checking bench for the core timing sequencer
`default_nettype none
module pmct_core_timing_bench;
    timeunit 1ns;
    timeprecision 100ps;
    logic clk_in, resetn_in, branch_taken_in, restart, stall, code_valid_in;
    logic code_ready_out, busy_out, retire_out, ret_taken_out, ret_undefined_out;
    logic [7:0] code_byte_in, ret_opcode_out, ret_operand1_out, ret_operand2_out;
    logic [1:0] ret_length_out;
    logic [3:0] ret_cycles_out;
    // Entry: {taken, opcode, length, cycles}
    logic [19:0] prog[$];
    int failures = 0;
    int n_checks = 0;
    pmct_core_timing DUT (.clk_in(clk_in), .resetn_in(resetn_in), .code_byte_in(code_byte_in),
        .code_valid_in(code_valid_in), .branch_taken_in(branch_taken_in),
        .code_ready_out(code_ready_out), .busy_out(busy_out), .retire_out(retire_out),
        .ret_opcode_out(ret_opcode_out), .ret_operand1_out(ret_operand1_out),
        .ret_operand2_out(ret_operand2_out), .ret_length_out(ret_length_out),
        .ret_cycles_out(ret_cycles_out), .ret_taken_out(ret_taken_out),
        .ret_undefined_out(ret_undefined_out));
    pmct_code_mem mem_u (.clk_in(clk_in), .restart_in(restart), .stall_in(stall),
        .ready_in(code_ready_out), .byte_out(code_byte_in), .valid_out(code_valid_in));
    initial begin
        clk_in = 1'b0;
        forever #12.5 clk_in = ~clk_in;
    end
    task automatic check(input logic [7:0] seen, input logic [7:0] exp);
        n_checks++;
        if (seen !== exp) begin
            failures++;
            $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic test_done;
        $display("checks %0d failures %0d", n_checks, failures);
        if (failures == 0 && n_checks > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask
    task automatic run(input logic bt, input logic st);
        int n;
        int w;
        restart = 1'b1;
        branch_taken_in = bt;
        stall = st;
        n = 0;
        foreach (prog[i]) for (int k = 0; k < prog[i][7:4]; k++) begin
            mem_u.mem_q[n] = (k == 0) ? prog[i][15:8] : 8'h3b + 8'(k);
            n++;
        end
        mem_u.fill = n;
        @(posedge clk_in);
        #2 restart = 1'b0;
        foreach (prog[i]) begin
            w = 0;
            do begin
                @(posedge clk_in);
                #2 w++;
            end while (retire_out !== 1'b1 && w < 40);
            check(8'(retire_out), 8'h01);
            check(ret_opcode_out, prog[i][15:8]);
            check(8'(ret_length_out), 8'(prog[i][7:4]));
            check(8'(ret_cycles_out), 8'(prog[i][3:0]));
            check(8'(ret_taken_out), 8'(prog[i][19:16]));
            check(ret_operand1_out, prog[i][7:4] > 1 ? 8'h3c : 8'h00);
            check(ret_operand2_out, prog[i][7:4] > 2 ? 8'h3d : 8'h00);
            check(8'(ret_undefined_out), 8'(prog[i][15:8] == 8'ha5));
        end
    endtask
    task automatic t_alu;
        prog = '{20'h02811, 20'h03911, 20'h09a11, 20'h05b11, 20'h04c11, 20'h06f11,
            20'h02522, 20'h03522, 20'h02612, 20'h09712, 20'h02422, 20'h06422,
            20'h05333, 20'h04333, 20'h06333, 20'h05222, 20'h04222, 20'h06222,
            20'h00522, 20'h01522, 20'h00612, 20'h01712,
            20'h0a511};
        run(1'b0, 1'b0);
    endtask
    task automatic t_long;
        // Slow memory: fetch stalls must not add to the counts
        prog = '{20'h08418, 20'h0a414, 20'h02215, 20'h02811, 20'h02422};
        run(1'b0, 1'b1);
    endtask
    task automatic t_branch;
        for (int bt = 0; bt < 2; bt++) begin
            prog = '{{4'(bt), 8'h40, 4'h2, 4'(2 + bt)}, {4'(bt), 8'h10, 4'h3, 4'(3 + bt)},
                {4'(bt), 8'hb6, 4'h3, 4'(4 + bt)}, {4'(bt), 8'h70, 4'h2, 4'(2 + bt)}};
            run(1'(bt), 1'b0);
        end
    endtask
    initial begin
        resetn_in = 1'b0;
        branch_taken_in = 1'b0;
        restart = 1'b1;
        stall = 1'b0;
        repeat (16) @(posedge clk_in);
        #2 resetn_in = 1'b1;
        t_alu();
        t_long();
        t_branch();
        test_done();
    end
    // Whole run needs well under 300 clocks; allow ten times that
    initial begin
        #75000;
        failures++;
        test_done();
    end
endmodule
`default_nettype wire
